// *** verilog/msp_pkg.sv ***
/*
  Constants, register map and types shared by the multidrop serial port.
  Assumes a single system clock at CLK_HZ and a 32-bit APB register bus.
*/
package msp_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CHAR_BITS     = 7;
  localparam int unsigned FRAME_BITS    = 10;
  localparam int unsigned DIV_W         = 19;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 32;

  localparam int unsigned BAUD_CODES = 6;
  localparam int unsigned RATE_BPS [0:BAUD_CODES-1] = '{300, 600, 1200, 2400, 4800, 9600};

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TXD  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RXD  = 8'h0C;

  localparam int unsigned CTRL_STN_LSB  = 0;
  localparam int unsigned CTRL_BAUD_LSB = 4;
  localparam int unsigned CTRL_PAR_LSB  = 8;
  localparam int unsigned CTRL_PORT_BIT = 12;

  localparam int unsigned STAT_ONLINE   = 0;
  localparam int unsigned STAT_RXVALID  = 1;
  localparam int unsigned STAT_OVERRUN  = 2;
  localparam int unsigned STAT_TXBUSY   = 3;
  localparam int unsigned STAT_TXEMPTY  = 4;
  localparam int unsigned STAT_TXFULL   = 5;

  localparam logic [CHAR_BITS-1:0] CHAR_CR       = 7'h0D;
  localparam logic [CHAR_BITS-1:0] CHAR_DIGIT0   = 7'h30;
  localparam logic [CHAR_BITS-1:0] CHAR_HEX_BASE = 7'h37;
  localparam logic [3:0]           STN_TEN       = 4'hA;

  typedef enum logic [2:0] {
    BAUD_300, BAUD_600, BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600
  } msp_baud_t;

  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} msp_parity_t;

  typedef enum logic {PORT_SERIAL, PORT_PARALLEL} msp_port_t;

  localparam logic [3:0]  STN_RST  = 4'h0;
  localparam msp_baud_t   BAUD_RST = BAUD_9600;
  localparam msp_parity_t PAR_RST  = PAR_EVEN;
endpackage : msp_pkg

// *** verilog/msp_stream_if.sv ***
/*
  Valid/ready stream carrier between the serial port's own modules.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface msp_stream_if #(parameter int unsigned W = 7);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : msp_stream_if

// *** verilog/msp_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; full refuses pushes, empty withholds valid.
*/
`timescale 1ns/1ps
module msp_fifo #(
  parameter int unsigned W     = 7,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  msp_stream_if.snk   fill,
  msp_stream_if.src   drain,
  output wire logic   empty,
  output wire logic   full
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0]  wrPtr_r;
  logic [AW:0]  rdPtr_r;
  wire          push = fill.valid && fill.ready;
  wire          pop  = drain.valid && drain.ready;

  assign empty       = wrPtr_r == rdPtr_r;
  assign full        = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

  a_fifo_no_overfill: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    full && !pop |=> full && $stable(wrPtr_r))
    else $error("fifo pointer moved while full");
endmodule : msp_fifo

// *** verilog/msp_rx.sv ***
/*
  Character receiver: start bit, seven data bits, parity, stop.
  Assumes rxLine is synchronous to clk_sys and idles high.
*/
`timescale 1ns/1ps
module msp_rx (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     rxLine,
  input  wire logic [msp_pkg::DIV_W-1:0] bitCyc,
  msp_stream_if.src                     charOut
);
  import msp_pkg::*;

  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} msp_rxst_t;

  msp_rxst_t              state_r;
  logic [DIV_W-1:0]       cnt_r;
  logic [2:0]             bitIdx_r;
  logic [CHAR_BITS:0]     shift_r;
  logic [CHAR_BITS-1:0]   data_r;
  logic                   valid_r;
  wire                    tick = cnt_r == '0;

  assign charOut.valid = valid_r;
  assign charOut.data  = data_r;

  // half a bit first, then whole bits: sampling lands mid-bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= R_IDLE;
      cnt_r    <= '0;
      bitIdx_r <= '0;
      shift_r  <= '0;
    end else begin
      unique case (state_r)
        R_IDLE: begin
          if (!rxLine) begin
            cnt_r   <= bitCyc >> 1; // [RULE_12]
            state_r <= R_START;
          end
        end
        R_START: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (rxLine) begin
            state_r <= R_IDLE; // [RULE_12]
          end else begin
            cnt_r    <= bitCyc - 1'b1;
            bitIdx_r <= '0;
            state_r  <= R_DATA;
          end
        end
        R_DATA: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            shift_r  <= {rxLine, shift_r[CHAR_BITS:1]}; // [RULE_11]
            cnt_r    <= bitCyc - 1'b1;
            bitIdx_r <= bitIdx_r + 1'b1;
            if (bitIdx_r == 3'h7) begin
              state_r <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (!tick) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= R_IDLE;
          end
        end
      endcase
    end
  end

  // parity bit shift_r[7] is dropped unchecked; a bad stop bit drops the char
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= 1'b0;
      data_r  <= '0;
    end else if (state_r == R_STOP && tick && rxLine) begin
      valid_r <= 1'b1;
      data_r  <= shift_r[CHAR_BITS-1:0]; // [RULE_06]
    end else if (charOut.ready) begin
      valid_r <= 1'b0;
    end
  end

  a_rx_false_start: assert property ( // [RULE_12]
    @(posedge clk_sys) disable iff (!arst_n)
    state_r == R_START && tick && rxLine |=> state_r == R_IDLE && !valid_r)
    else $error("false start not rejected");
endmodule : msp_rx

// *** verilog/msp_serial_port.sv ***
/*
  Multidrop serial port: APB registers, station online logic, transmit path
  through a FIFO, and the receiver. Assumes one clock clk_sys, the line
  idles high, and the master terminal checks parity of what it receives.
*/
// Notes on behaviour
// [RULE_01] station zero means always online; carriage return never takes it offline
// [RULE_02] queued replies are sent whenever present, regardless of station or online state
// [RULE_03] six line speeds 300 to 9600, one stored choice for both directions
// [RULE_04] even mode clears parity on odd data count; odd mode sets it
// [RULE_05] mark forces parity one, space forces parity zero, every character
// [RULE_06] receiver ignores the parity bit, no check and no error flag
// [RULE_07] master terminal alone checks parity against the configured setting
// [RULE_08] port choice offers serial and parallel; only serial works
// [RULE_09] station number is a setting from zero to fifteen
// [RULE_10] nonzero station: online on own number, offline again on carriage return
// [RULE_11] frame is start, seven data, parity, stop: ten bit times
// [RULE_12] bit time from system clock by selected divider; receive samples mid-bit
`timescale 1ns/1ps
module msp_serial_port #(
  parameter int unsigned CLK_HZ_P = msp_pkg::CLK_HZ
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [msp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output wire logic [31:0]               prdata,
  output wire logic                      pready,
  output wire logic                      pslverr,
  input  wire logic                      rxLine,
  output wire logic                      txLine,
  output wire logic                      online
);
  import msp_pkg::*;

  localparam logic [DIV_W-1:0] BIT_CYC [0:BAUD_CODES-1] = '{
    DIV_W'(CLK_HZ_P / RATE_BPS[0]),
    DIV_W'(CLK_HZ_P / RATE_BPS[1]),
    DIV_W'(CLK_HZ_P / RATE_BPS[2]),
    DIV_W'(CLK_HZ_P / RATE_BPS[3]),
    DIV_W'(CLK_HZ_P / RATE_BPS[4]),
    DIV_W'(CLK_HZ_P / RATE_BPS[5])
  };

  typedef enum logic {TX_IDLE, TX_SEND} msp_txst_t;

  // configuration
  logic [3:0]             station_r;
  msp_baud_t              baudSel_r;
  msp_parity_t            parity_r;
  logic [DIV_W-1:0]       bitCyc;

  // online and receive holding
  logic                   onlineNz_r;
  logic [CHAR_BITS-1:0]   rxData_r;
  logic                   rxValid_r;
  logic                   rxOverrun_r;
  logic [CHAR_BITS-1:0]   idChar;
  logic                   stnZero;
  logic                   rxTake;

  // transmit
  msp_txst_t              txState_r;
  logic [FRAME_BITS-1:0]  frame_r;
  logic [DIV_W-1:0]       txCnt_r;
  logic [3:0]             txBits_r;
  logic                   txEmpty;
  logic                   txFull;
  logic                   parBit;

  // bus
  logic [31:0]            prdata_r;
  logic                   setup;
  logic                   access;
  logic                   mapped;
  logic                   done;
  logic                   wrCtrl;
  logic                   rdRxd;

  msp_stream_if #(.W(CHAR_BITS)) txIn ();
  msp_stream_if #(.W(CHAR_BITS)) txOut ();
  msp_stream_if #(.W(CHAR_BITS)) rxIf ();

  // one divider serves both directions
  assign bitCyc = BIT_CYC[baudSel_r]; // [RULE_03] [RULE_12]

  // ---- APB slave
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) ||
                   (paddr == ADDR_TXD)  || (paddr == ADDR_RXD);
  // a data write waits here while the transmit queue is full
  assign pready  = !(access && pwrite && (paddr == ADDR_TXD) && !txIn.ready);
  assign pslverr = access && !mapped;
  assign done    = access && pready;
  assign wrCtrl  = done && pwrite && (paddr == ADDR_CTRL);
  assign rdRxd   = done && !pwrite && (paddr == ADDR_RXD);
  assign prdata  = prdata_r;

  assign txIn.valid = access && pwrite && (paddr == ADDR_TXD);
  assign txIn.data  = pwdata[CHAR_BITS-1:0];

  // read data is picked up in the setup phase so it comes from a flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= '0;
    end else if (setup) begin
      prdata_r <= '0;
      unique case (paddr)
        ADDR_CTRL: begin
          prdata_r[CTRL_STN_LSB +: 4]  <= station_r;
          prdata_r[CTRL_BAUD_LSB +: 3] <= baudSel_r;
          prdata_r[CTRL_PAR_LSB +: 2]  <= parity_r;
          prdata_r[CTRL_PORT_BIT]      <= PORT_SERIAL; // [RULE_08]
        end
        ADDR_STAT: begin
          prdata_r[STAT_ONLINE]  <= online;
          prdata_r[STAT_RXVALID] <= rxValid_r;
          prdata_r[STAT_OVERRUN] <= rxOverrun_r;
          prdata_r[STAT_TXBUSY]  <= txState_r == TX_SEND;
          prdata_r[STAT_TXEMPTY] <= txEmpty;
          prdata_r[STAT_TXFULL]  <= txFull;
        end
        ADDR_RXD: begin
          prdata_r[CHAR_BITS-1:0] <= rxData_r;
        end
        default: begin
          prdata_r <= '0;
        end
      endcase
    end
  end

  // ---- configuration register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      station_r <= STN_RST;
      baudSel_r <= BAUD_RST;
      parity_r  <= PAR_RST;
    end else if (wrCtrl) begin
      station_r <= pwdata[CTRL_STN_LSB +: 4]; // [RULE_09]
      parity_r  <= msp_parity_t'(pwdata[CTRL_PAR_LSB +: 2]);
      // codes beyond the six rates keep the old speed
      if (pwdata[CTRL_BAUD_LSB +: 3] < 3'(BAUD_CODES)) begin
        baudSel_r <= msp_baud_t'(pwdata[CTRL_BAUD_LSB +: 3]); // [RULE_03]
      end
    end
  end

  // ---- station addressing
  assign stnZero = station_r == 4'h0;
  assign rxTake  = rxIf.valid;
  assign rxIf.ready = 1'b1;
  // station shown as one hex digit: 1..9 then A..F
  assign idChar  = (station_r < STN_TEN) ? (CHAR_DIGIT0 + {3'h0, station_r})
                                         : (CHAR_HEX_BASE + {3'h0, station_r});
  assign online  = stnZero || onlineNz_r; // [RULE_01]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      onlineNz_r <= 1'b0;
    end else if (stnZero) begin
      onlineNz_r <= 1'b0; // [RULE_01]
    end else if (rxTake && onlineNz_r && rxIf.data == CHAR_CR) begin
      onlineNz_r <= 1'b0; // [RULE_10]
    end else if (rxTake && rxIf.data == idChar) begin
      onlineNz_r <= 1'b1; // [RULE_10]
    end
  end

  // ---- receive holding register, only fed while online
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxData_r <= '0;
    end else if (rxTake && online) begin
      rxData_r <= rxIf.data; // [RULE_10]
    end
  end

  // set wins over the clear by a read in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxValid_r <= 1'b0;
    end else if (rxTake && online) begin
      rxValid_r <= 1'b1;
    end else if (rdRxd) begin
      rxValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxOverrun_r <= 1'b0;
    end else if (rxTake && online && rxValid_r && !rdRxd) begin
      rxOverrun_r <= 1'b1;
    end else if (rdRxd) begin
      rxOverrun_r <= 1'b0;
    end
  end

  msp_rx u_rx (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .rxLine  (rxLine),
    .bitCyc  (bitCyc),
    .charOut (rxIf)
  );

  // ---- transmit queue
  msp_fifo #(.W(CHAR_BITS), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .fill    (txIn),
    .drain   (txOut),
    .empty   (txEmpty),
    .full    (txFull)
  );

  // ---- parity of the outgoing character
  always_comb begin
    unique case (parity_r)
      PAR_EVEN:  parBit = ~^txOut.data; // [RULE_04]
      PAR_ODD:   parBit = ^txOut.data; // [RULE_04]
      PAR_MARK:  parBit = 1'b1; // [RULE_05]
      PAR_SPACE: parBit = 1'b0; // [RULE_05]
    endcase
  end

  // not gated by online: replies leave as soon as the line is free
  assign txOut.ready = txState_r == TX_IDLE; // [RULE_02]

  // frame_r[0] is the line; ones shift in behind so it idles high
  assign txLine = frame_r[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txState_r <= TX_IDLE;
      frame_r   <= '1;
      txCnt_r   <= '0;
      txBits_r  <= '0;
    end else begin
      unique case (txState_r)
        TX_IDLE: begin
          if (txOut.valid) begin
            frame_r   <= {1'b1, parBit, txOut.data, 1'b0}; // [RULE_11]
            txCnt_r   <= bitCyc - 1'b1; // [RULE_12]
            txBits_r  <= 4'(FRAME_BITS - 1);
            txState_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (txCnt_r != '0) begin
            txCnt_r <= txCnt_r - 1'b1;
          end else begin
            frame_r <= {1'b1, frame_r[FRAME_BITS-1:1]};
            txCnt_r <= bitCyc - 1'b1;
            if (txBits_r == 4'h0) begin
              txState_r <= TX_IDLE;
            end else begin
              txBits_r <= txBits_r - 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ---- checks
  a_zero_stays_on: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (!arst_n)
    stnZero && rxTake && rxIf.data == CHAR_CR && !wrCtrl |=> online)
    else $error("station zero went offline");

  a_id_goes_on: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (!arst_n)
    !stnZero && rxTake && rxIf.data == idChar && !wrCtrl |=> online)
    else $error("own station number did not bring port online");

  a_cr_goes_off: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (!arst_n)
    !stnZero && onlineNz_r && rxTake && rxIf.data == CHAR_CR && !wrCtrl
    |=> !online ##1 !online)
    else $error("carriage return did not take port offline");

  a_offline_drop: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (!arst_n)
    rxTake && !online && !rdRxd |=> $stable(rxValid_r) && $stable(rxData_r))
    else $error("character stored while offline");

  a_reply_starts: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (!arst_n)
    txState_r == TX_IDLE && !txEmpty |=> txState_r == TX_SEND && !txLine)
    else $error("queued reply not started");

  a_even_parity: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (!arst_n)
    txState_r == TX_IDLE && txOut.valid && parity_r == PAR_EVEN
    |=> frame_r[8] == ~^frame_r[7:1])
    else $error("even parity bit wrong");

  a_odd_parity: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (!arst_n)
    txState_r == TX_IDLE && txOut.valid && parity_r == PAR_ODD
    |=> frame_r[8] == ^frame_r[7:1])
    else $error("odd parity bit wrong");

  a_forced_parity: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (!arst_n)
    txState_r == TX_IDLE && txOut.valid && parity_r inside {PAR_MARK, PAR_SPACE}
    |=> frame_r[8] == (parity_r == PAR_MARK))
    else $error("forced parity bit wrong");

  a_frame_shape: assert property ( // [RULE_11]
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(txState_r == TX_SEND) |-> !frame_r[0] && frame_r[9] && txBits_r == 4'h9)
    else $error("frame does not hold start and stop bits");

  a_baud_guard: assert property ( // [RULE_03]
    @(posedge clk_sys) disable iff (!arst_n)
    wrCtrl && pwdata[CTRL_BAUD_LSB +: 3] >= 3'(BAUD_CODES) |=> $stable(baudSel_r))
    else $error("illegal speed code accepted");

  a_port_serial: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (!arst_n)
    access && !pwrite && paddr == ADDR_CTRL |-> !prdata[CTRL_PORT_BIT])
    else $error("parallel port choice reads back");
endmodule : msp_serial_port

// *** bench/msp_terminal_model.sv ***
/*
  Master terminal model on the far side of the serial line.
  Assumes the bench keeps bitCyc and parMode equal to the port setting.
*/
`timescale 1ns/1ps
module msp_terminal_model (
  input  wire logic                 clk_sys,
  input  wire logic                 lineIn,
  input  wire logic [15:0]          bitCyc,
  input  wire msp_pkg::msp_parity_t parMode,
  output logic                      lineOut
);
  import msp_pkg::*;
  logic [6:0] rxChars [$];
  logic       rxPars [$];
  int         parErrs = 0;
  int         frameErrs = 0;
  initial lineOut = 1'b1;

  function automatic logic wantPar(msp_parity_t m, logic [6:0] c);
    case (m)
      PAR_EVEN: return ~^c;
      PAR_ODD:  return ^c;
      PAR_MARK: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction : wantPar

  // line rests high after the stop bit, as an idle line does
  task automatic sendChar(input logic [6:0] c, input logic p);
    logic [9:0] fr;
    fr = {1'b1, p, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lineOut <= fr[i];
      repeat (bitCyc) @(posedge clk_sys);
    end
  endtask : sendChar

  // sampled on falling edges, clear of the rising edges where the line moves;
  // sh[8] is the stop bit, so a back-to-back start is not swallowed
  always begin : rxLoop
    logic [8:0] sh;
    @(negedge clk_sys);
    if (lineIn === 1'b0) begin
      repeat (bitCyc / 2) @(negedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (bitCyc) @(negedge clk_sys);
        sh[i] = lineIn;
      end
      if (sh[8] !== 1'b1) frameErrs++;
      if (sh[7] !== wantPar(parMode, sh[6:0])) parErrs++;
      rxChars.push_back(sh[6:0]);
      rxPars.push_back(sh[7]);
    end
  end
endmodule : msp_terminal_model

// *** bench/tb.sv ***
/*
  Self-checking bench for the multidrop serial port over APB.
  Assumes a lowered CLK_HZ_P so that bit times stay short.
*/
`timescale 1ns/1ps
module tb;
  import msp_pkg::*;
  localparam int unsigned CLKP = 96_000; // 10 cycles a bit at 9600
  logic              clk_sys, arst_n, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, rxLine, txLine, online, err;
  logic [15:0]       bitCyc;
  msp_parity_t       parMode;
  int                nMismatch = 0;
  int                checksDone = 0;

  msp_serial_port #(.CLK_HZ_P(CLKP)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txLine(txLine), .online(online));
  msp_terminal_model term (.clk_sys(clk_sys), .lineIn(txLine), .bitCyc(bitCyc),
    .parMode(parMode), .lineOut(rxLine));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrapUp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready looked at between edges, so a flop moving on the edge cannot fool us
    @(negedge clk_sys);
    while (pready !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 5000) nMismatch++;
  endtask : apb

  task automatic cfg(input logic [3:0] s, input int b, input msp_parity_t p);
    apb(1'b1, ADDR_CTRL, (32'(p) << CTRL_PAR_LSB) | (32'(b) << CTRL_BAUD_LSB) | 32'(s));
    bitCyc <= 16'(CLKP / RATE_BPS[b]);
    parMode <= p;
  endtask : cfg

  task automatic waitRx(input int k);
    int n;
    n = 0;
    while (term.rxChars.size() < k && n < 50000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("terminal char count", 32'(k), 32'(term.rxChars.size()));
  endtask : waitRx

  task automatic txCheck(input logic [6:0] c);
    apb(1'b1, ADDR_TXD, 32'(c));
    waitRx(1);
    chk("tx char", 32'(c), 32'(term.rxChars.pop_front()));
    chk("tx parity", 32'(term.wantPar(parMode, c)), 32'(term.rxPars.pop_front()));
  endtask : txCheck

  // receiver delivers at mid stop; online follows a cycle later
  task automatic toDut(input logic [6:0] c, input logic badPar);
    term.sendChar(c, term.wantPar(parMode, c) ^ badPar);
    repeat (2) @(posedge clk_sys);
  endtask : toDut

  initial begin
    repeat (60000) @(posedge clk_sys);
    nMismatch++;
    wrapUp();
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bitCyc = 16'(CLKP / 9600);
    parMode = PAR_EVEN;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, '0);
    chk("ctrl reset", 32'h50, rd);
    apb(1'b0, ADDR_STAT, '0);
    chk("stat reset", 32'h11, rd);
    chk("online reset", 32'h1, 32'(online));
    apb(1'b1, ADDR_CTRL, 32'h1050);
    apb(1'b0, ADDR_CTRL, '0);
    chk("parallel choice", 32'h50, rd);
    apb(1'b0, 8'h10, '0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("registers done");
    for (int b = 0; b < 6; b++) begin
      cfg(4'h0, b, PAR_EVEN);
      txCheck(7'h55);
    end
    for (int p = 0; p < 4; p++) begin
      cfg(4'h0, 5, msp_parity_t'(p));
      txCheck(7'h41);
      txCheck(7'h43);
    end
    $display("rates and parity done");
    cfg(4'hF, 5, PAR_ODD);
    apb(1'b0, ADDR_CTRL, '0);
    chk("station fifteen", 32'h15F, rd);
    chk("offline before id", 32'h0, 32'(online));
    txCheck(7'h3F);
    toDut(7'h46, 1'b1);
    chk("online on id", 32'h1, 32'(online));
    toDut(7'h5A, 1'b1);
    apb(1'b0, ADDR_RXD, '0);
    chk("bad parity char", 32'h5A, rd);
    toDut(CHAR_CR, 1'b0);
    chk("offline on cr", 32'h0, 32'(online));
    cfg(4'h0, 5, PAR_EVEN);
    toDut(CHAR_CR, 1'b0);
    chk("station zero online", 32'h1, 32'(online));
    apb(1'b0, ADDR_RXD, '0);
    chk("cr stored", 32'h0D, rd);
    // speed code 7 keeps the old rate, the other fields still land
    apb(1'b1, ADDR_CTRL, 32'h370);
    apb(1'b0, ADDR_CTRL, '0);
    chk("illegal speed kept", 32'h350, rd);
    // low pulse well under half a bit must not start a character
    term.lineOut <= 1'b0;
    repeat (2) @(posedge clk_sys);
    term.lineOut <= 1'b1;
    repeat (120) @(posedge clk_sys);
    apb(1'b0, ADDR_STAT, '0);
    chk("glitch ignored", 32'h11, rd);
    $display("station done");
    // slower rate so the fifo fills long before the first frame ends
    cfg(4'h0, 4, PAR_EVEN);
    for (int i = 0; i < 33; i++) apb(1'b1, ADDR_TXD, 32'(32'h20 + i));
    apb(1'b0, ADDR_STAT, '0);
    chk("fifo full", 32'h1, 32'(rd[STAT_TXFULL]));
    apb(1'b1, ADDR_TXD, 32'h41);
    waitRx(34);
    for (int i = 0; i < 34; i++) chk("fifo order", (i < 33) ? 32'(32'h20 + i) : 32'h41,
      32'(term.rxChars.pop_front()));
    term.rxPars.delete();
    repeat (bitCyc) @(posedge clk_sys);
    apb(1'b0, ADDR_STAT, '0);
    chk("stat drained", 32'h11, rd);
    chk("terminal parity errors", 32'h0, 32'(term.parErrs));
    chk("terminal frame errors", 32'h0, 32'(term.frameErrs));
    $display("fifo done");
    wrapUp();
  end
endmodule : tb
